//--- float_special_unit.sv
// float special unit: pipelined adder, pipelined multiplier, iterative divider
//
// Summary of operation
// - adder is three-stage pipelined, one op per clock, result 3 clocks later.
// - adder runs add, subtract, three float-to-int conversions and int-to-float.
// - multiplier is three-stage pipelined, one op per clock, 3 clock latency.
// - one multiplier serves float, signed, unsigned, double-width and pixel multiply.
// - divider is iterative, refuses new divides until the current completes.
// - divider gives exact quotients for float, signed and unsigned integer divide.
// - integer divides take 19 clocks, double-width unsigned divide takes 30.
// - float divides take 13 single, 23 double, 26 extended clocks.
// - square root is not built; issuing it raises the unimplemented exception.
`timescale 1ns/1ps
module float_special_unit
   import fp_exec_pkg::*;
(
   input  wire logic    clk_i,
   input  wire logic    rstn_i,
   input  wire logic    issue_valid_i,
   input  wire issue_t  issue_i,
   output result_t      add_res_o,
   output result_t      mul_res_o,
   output result_t      div_res_o,
   output logic         div_busy_o,
   output logic         div_refused_o,
   output logic         unimp_exc_o,
   output logic [TAG_W-1:0] unimp_tag_o
);

   typedef enum logic [1:0] {
      DIV_IDLE, DIV_RUN
   } div_state_t;

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------

   // integer view of the low operand word (float bit-level datapath abstracted)
   function automatic logic [63:0] sext32(input logic [63:0] v);
      return {{32{v[31]}}, v[31:0]};
   endfunction

   // divide latency for an accepted divide
   function automatic logic [4:0] div_cycles(input op_t op, input prec_t p);
      logic [4:0] n;
      n = 5'(DIV_INT_LAT);
      unique case (op)
         OP_DIVU_D: n = 5'(DIV_DBL_LAT);
         OP_FDIV: begin
            unique case (p)
               PREC_SGL: n = 5'(FDIV_SGL_LAT);
               PREC_DBL: n = 5'(FDIV_DBL_LAT);
               default:  n = 5'(FDIV_EXT_LAT);
            endcase
         end
         default: n = 5'(DIV_INT_LAT);
      endcase
      return n;
   endfunction

   // --------------------------------------------------------------
   // adder pipeline
   // --------------------------------------------------------------
   logic              add_v   [ADD_LAT];
   logic [TAG_W-1:0]  add_tag [ADD_LAT];
   logic [63:0]       add_val [ADD_LAT];
   logic [63:0]       next_add;
   logic              add_sel;

   assign add_sel = issue_valid_i && (issue_i.op inside
                    {OP_FADD, OP_FSUB, OP_INT, OP_NINT, OP_TRNC, OP_FLT});

   // first stage operation select
   always_comb begin
      next_add = '0;
      unique case (issue_i.op)
         OP_FADD: next_add = issue_i.a + issue_i.b;
         OP_FSUB: next_add = issue_i.a - issue_i.b;
         OP_INT:  next_add = sext32(issue_i.a);
         OP_NINT: next_add = sext32(issue_i.a + 64'h0000_0000_0000_0001);
         OP_TRNC: next_add = sext32(issue_i.a);
         OP_FLT:  next_add = sext32(issue_i.b);
         default: next_add = '0;
      endcase
   end

   // three stages, one accept per clock
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < ADD_LAT; i++) begin
            add_v[i]   <= 1'b0;
            add_tag[i] <= '0;
            add_val[i] <= '0;
         end
      end else begin
         add_v[0]   <= add_sel;
         add_tag[0] <= issue_i.tag;
         add_val[0] <= next_add;
         for (int i = 1; i < ADD_LAT; i++) begin
            add_v[i]   <= add_v[i-1];
            add_tag[i] <= add_tag[i-1];
            add_val[i] <= add_val[i-1];
         end
      end
   end

   assign add_res_o = '{valid: add_v[ADD_LAT-1], tag: add_tag[ADD_LAT-1],
                        value: add_val[ADD_LAT-1]};

   // --------------------------------------------------------------
   // shared multiplier pipeline
   // --------------------------------------------------------------
   logic              mul_v   [MUL_LAT];
   logic [TAG_W-1:0]  mul_tag [MUL_LAT];
   logic [63:0]       mul_val [MUL_LAT];
   logic [127:0]      mul_full;
   logic              mul_sel;

   assign mul_sel = issue_valid_i && (issue_i.op inside
                    {OP_FMUL, OP_MULU, OP_MULU_D, OP_MULS, OP_PMUL});

   // one array, operand shaping per operation
   always_comb begin
      mul_full = '0;
      unique case (issue_i.op)
         OP_MULS:  mul_full = 128'($signed(sext32(issue_i.a)) * $signed(sext32(issue_i.b)));
         OP_PMUL:  mul_full = {64'h0, issue_i.a[31:0]} * {64'h0, issue_i.b};
         OP_MULU_D,
         OP_MULU:  mul_full = {96'h0, issue_i.a[31:0]} * {96'h0, issue_i.b[31:0]};
         default:  mul_full = {64'h0, issue_i.a} * {64'h0, issue_i.b};
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < MUL_LAT; i++) begin
            mul_v[i]   <= 1'b0;
            mul_tag[i] <= '0;
            mul_val[i] <= '0;
         end
      end else begin
         mul_v[0]   <= mul_sel;
         mul_tag[0] <= issue_i.tag;
         mul_val[0] <= (issue_i.op == OP_MULU || issue_i.op == OP_MULS)
                       ? {32'h0, mul_full[31:0]} : mul_full[63:0];
         for (int i = 1; i < MUL_LAT; i++) begin
            mul_v[i]   <= mul_v[i-1];
            mul_tag[i] <= mul_tag[i-1];
            mul_val[i] <= mul_val[i-1];
         end
      end
   end

   assign mul_res_o = '{valid: mul_v[MUL_LAT-1], tag: mul_tag[MUL_LAT-1],
                        value: mul_val[MUL_LAT-1]};

   // --------------------------------------------------------------
   // iterative divider
   // --------------------------------------------------------------
   div_state_t        div_state;
   logic [4:0]        div_left;
   logic [TAG_W-1:0]  div_tag;
   logic [63:0]       div_q;
   logic              div_sel;
   logic              div_take;
   logic [63:0]       next_q;

   assign div_sel  = issue_valid_i && (issue_i.op inside
                     {OP_FDIV, OP_DIVS, OP_DIVU, OP_DIVU_D});
   assign div_take = div_sel && div_state == DIV_IDLE;

   // exact quotient; divide by zero yields zero
   always_comb begin
      next_q = '0;
      if (issue_i.b != '0) begin
         unique case (issue_i.op)
            OP_DIVS: next_q = 64'($signed(sext32(issue_i.a)) / $signed(sext32(issue_i.b)));
            OP_DIVU: next_q = {32'h0, issue_i.a[31:0] / issue_i.b[31:0]};
            default: next_q = issue_i.a / issue_i.b;
         endcase
      end
   end

   // latency counter; the result leaves when the count expires
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         div_state <= DIV_IDLE;
         div_left  <= '0;
         div_tag   <= '0;
         div_q     <= '0;
         div_busy_o <= 1'b0;
         div_res_o <= '0;
      end else begin
         div_res_o.valid <= 1'b0;
         unique case (div_state)
            DIV_IDLE: begin
               if (div_take) begin
                  div_state  <= DIV_RUN;
                  div_left   <= div_cycles(issue_i.op, issue_i.prec) - 5'd1;
                  div_tag    <= issue_i.tag;
                  div_q      <= next_q;
                  div_busy_o <= 1'b1;
               end
            end
            DIV_RUN: begin
               if (div_left == 5'd1) begin
                  div_state  <= DIV_IDLE;
                  div_busy_o <= 1'b0;
                  div_res_o  <= '{valid: 1'b1, tag: div_tag, value: div_q};
               end
               div_left <= div_left - 5'd1;
            end
         endcase
      end
   end

   // refusal pulse for a divide offered while busy
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) div_refused_o <= 1'b0;
      else         div_refused_o <= div_sel && !div_take;
   end

   // --------------------------------------------------------------
   // square root trap
   // --------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         unimp_exc_o <= 1'b0;
         unimp_tag_o <= '0;
      end else begin
         unimp_exc_o <= issue_valid_i && issue_i.op == OP_FSQRT;
         unimp_tag_o <= issue_i.tag;
      end
   end

endmodule

//--- fp_exec_pkg.sv
// package of operation codes, latencies and carriers for the float special unit
package fp_exec_pkg;

   // unit latencies in clocks, and tag width in bits
   localparam int ADD_LAT      = 3;
   localparam int MUL_LAT      = 3;
   localparam int DIV_INT_LAT  = 19;
   localparam int DIV_DBL_LAT  = 30;
   localparam int FDIV_SGL_LAT = 13;
   localparam int FDIV_DBL_LAT = 23;
   localparam int FDIV_EXT_LAT = 26;
   localparam int TAG_W        = 6;

   // operation codes from issue logic
   typedef enum logic [4:0] {
      OP_FADD, OP_FSUB, OP_INT, OP_NINT, OP_TRNC, OP_FLT,
      OP_FMUL, OP_MULU, OP_MULU_D, OP_MULS, OP_PMUL,
      OP_FDIV, OP_DIVS, OP_DIVU, OP_DIVU_D, OP_FSQRT, OP_NONE
   } op_t;

   typedef enum logic [1:0] {
      PREC_SGL, PREC_DBL, PREC_EXT
   } prec_t;

   // issued operation
   typedef struct packed {
      op_t               op;
      prec_t             prec;
      logic [TAG_W-1:0]  tag;
      logic [63:0]       a;
      logic [63:0]       b;
   } issue_t;

   // completed result
   typedef struct packed {
      logic              valid;
      logic [TAG_W-1:0]  tag;
      logic [63:0]       value;
   } result_t;

endpackage

//--- fsu_assertions.sv
// port checker for the float special unit
`timescale 1ns/1ps
module fsu_checker
   import fp_exec_pkg::*;
(
   input wire logic             clk_i,
   input wire logic             rstn_i,
   input wire logic             issue_valid_i,
   input wire issue_t           issue_i,
   input wire result_t          add_res_o,
   input wire result_t          mul_res_o,
   input wire result_t          div_res_o,
   input wire logic             div_busy_o,
   input wire logic             div_refused_o,
   input wire logic             unimp_exc_o,
   input wire logic [TAG_W-1:0] unimp_tag_o
);
   logic dv;
   logic acc;
   // divide offered, and divide actually taken
   assign dv  = issue_valid_i && (issue_i.op inside {[OP_FDIV:OP_DIVU_D]});
   assign acc = dv && !div_busy_o;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   AST_ADD_LAT:
   assert property (issue_valid_i && issue_i.op inside {[OP_FADD:OP_FLT]} |->
      ##3 add_res_o.valid && add_res_o.tag == $past(issue_i.tag, 3)) else $error("adder late");
   AST_MUL_LAT:
   assert property (issue_valid_i && issue_i.op inside {[OP_FMUL:OP_PMUL]} |->
      ##3 mul_res_o.valid && mul_res_o.tag == $past(issue_i.tag, 3)) else $error("mul late");
   AST_DIV_BUSY:
   assert property (acc |=> div_busy_o) else $error("divider not busy");
   AST_DIV_REFUSE:
   assert property (dv && div_busy_o |=> div_refused_o) else $error("divide not refused");
   AST_DIV_QUIET:
   assert property (div_busy_o |-> !div_res_o.valid) else $error("result while busy");
   AST_DIV_INT:
   assert property (acc && issue_i.op inside {OP_DIVS, OP_DIVU} |-> ##19 div_res_o.valid)
      else $error("int divide latency");
   AST_DIV_WIDE:
   assert property (acc && issue_i.op == OP_DIVU_D |-> ##30 div_res_o.valid)
      else $error("wide divide latency");
   AST_FDIV_SGL:
   assert property (acc && issue_i.op == OP_FDIV && issue_i.prec == PREC_SGL |->
      ##13 div_res_o.valid) else $error("single fdiv latency");
   AST_UNIMP:
   assert property (issue_valid_i && issue_i.op == OP_FSQRT |=>
      unimp_exc_o && unimp_tag_o == $past(issue_i.tag)) else $error("sqrt not trapped");
   AST_FDIV_DBL:
   assert property (acc && issue_i.op == OP_FDIV && issue_i.prec == PREC_DBL |->
      ##23 div_res_o.valid) else $error("double fdiv latency");
   AST_FDIV_EXT:
   assert property (acc && issue_i.op == OP_FDIV && issue_i.prec == PREC_EXT |->
      ##26 div_res_o.valid) else $error("extended fdiv latency");
   AST_NO_REFUSE:
   assert property (!(dv && div_busy_o) |=> !div_refused_o) else $error("false refusal");
   AST_UNIMP_ONLY:
   assert property (!(issue_valid_i && issue_i.op == OP_FSQRT) |=> !unimp_exc_o)
      else $error("spurious unimplemented trap");
endmodule
bind float_special_unit fsu_checker u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
   .issue_valid_i(issue_valid_i), .issue_i(issue_i), .add_res_o(add_res_o),
   .mul_res_o(mul_res_o), .div_res_o(div_res_o), .div_busy_o(div_busy_o),
   .div_refused_o(div_refused_o), .unimp_exc_o(unimp_exc_o), .unimp_tag_o(unimp_tag_o));

//--- issue_model.sv
// issue logic model feeding operations to the float special unit
`timescale 1ns/1ps
module issue_model
   import fp_exec_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic div_busy_i,
   output logic      issue_valid_o,
   output issue_t    issue_o
);
   // idle bus at time zero
   initial begin
      issue_valid_o = 1'b0;
      issue_o       = '0;
   end
   // one op per cycle; held ops wait while the divider is busy
   task automatic send(input issue_t t, input bit hold);
      int n;
      n = 0;
      @(posedge clk_i);
      #1;
      while (hold && div_busy_i && n < 40) begin
         issue_valid_o = 1'b0;
         @(posedge clk_i);
         #1;
         n++;
      end
      issue_valid_o = 1'b1;
      issue_o       = t;
   endtask
   // release; payload scrambled so stale data never looks valid
   task automatic idle();
      @(posedge clk_i);
      #1;
      issue_valid_o = 1'b0;
      issue_o       = issue_t'(~issue_o);
   endtask
endmodule

//--- float_special_unit_tb.sv
// self-checking bench for the float special unit
`timescale 1ns/1ps
module float_special_unit_tb
   import fp_exec_pkg::*;
;
   typedef struct {int due; logic [TAG_W-1:0] tag; logic [63:0] v; bit cv;} exp_t;
   logic             clk_i = 1'b0;
   logic             rstn_i = 1'b0;
   logic             issue_valid_i;
   issue_t           issue_i;
   result_t          add_res_o, mul_res_o, div_res_o, r;
   logic             div_busy_o, div_refused_o, unimp_exc_o;
   logic [TAG_W-1:0] unimp_tag_o, lt;
   int               err_count = 0, samples_checked = 0, cyc = 0, seed = 32'h853f, k;
   exp_t             q[3][$];
   exp_t             e;
   always #4 clk_i = ~clk_i;
   always @(posedge clk_i) cyc <= cyc + 1;
   float_special_unit u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .issue_valid_i(issue_valid_i),
      .issue_i(issue_i), .add_res_o(add_res_o), .mul_res_o(mul_res_o), .div_res_o(div_res_o),
      .div_busy_o(div_busy_o), .div_refused_o(div_refused_o), .unimp_exc_o(unimp_exc_o),
      .unimp_tag_o(unimp_tag_o));
   issue_model u_iss (.clk_i(clk_i), .div_busy_i(div_busy_o), .issue_valid_o(issue_valid_i),
      .issue_o(issue_i));
   task automatic chk(input string n, input logic [63:0] s, x);
      samples_checked++;
      if (s !== x) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // reference result of the ops whose value is defined
   function automatic logic [63:0] ev(op_t o, logic [63:0] a, b);
      case (o)
         OP_FADD: return a + b;
         OP_FSUB: return a - b;
         OP_FMUL: return a * b;
         OP_MULU, OP_MULS: return {32'h0, a[31:0] * b[31:0]};
         OP_MULU_D: return 64'(a[31:0]) * b[31:0];
         OP_PMUL: return 64'(a[31:0]) * b;
         OP_DIVS: return longint'($signed(a[31:0])) / longint'($signed(b[31:0]));
         OP_DIVU: return 64'(a[31:0] / b[31:0]);
         default: return a / b;
      endcase
   endfunction
   // issue one op and queue its expected result
   task automatic go(input op_t o, input prec_t p, input bit hold);
      issue_t t;
      int     u, l;
      t  = '{o, p, 6'(cyc), {$random(seed), $random(seed)}, {32'h0, $random(seed)} | 64'h1};
      u  = o <= OP_FLT ? 0 : o <= OP_PMUL ? 1 : 2;
      l  = u < 2 ? 3 : o == OP_DIVU_D ? 30 : o != OP_FDIV ? 19 : p == PREC_SGL ? 13 :
           p == PREC_DBL ? 23 : 26;
      u_iss.send(t, hold);
      if (hold) chk("hold", div_busy_o, 0);
      lt = t.tag;
      if (o == OP_FSQRT || (u == 2 && div_busy_o === 1'b1)) return;
      q[u].push_back('{cyc + l, t.tag, ev(o, t.a, t.b),
                       !(o inside {OP_INT, OP_NINT, OP_TRNC, OP_FLT})});
   endtask
   // compare every result pulse with the model, in order and on time
   always @(posedge clk_i) begin
      #2;
      for (int u = 0; u < 3; u++) begin
         r = u == 0 ? add_res_o : u == 1 ? mul_res_o : div_res_o;
         if (r.valid === 1'b1 && q[u].size() == 0) chk("spurious", 1, 0);
         else if (r.valid === 1'b1) begin
            e = q[u].pop_front();
            chk("due", 64'(cyc), 64'(e.due));
            chk("tag", r.tag, e.tag);
            if (e.cv) chk("value", r.value, e.v);
         end else if (q[u].size() > 0 && q[u][0].due <= cyc) begin
            void'(q[u].pop_front());
            chk("late", 0, 1);
         end
      end
   end
   // main sequence
   initial begin
      repeat (6) @(posedge clk_i);
      #1;
      chk("reset", {add_res_o.valid, mul_res_o.valid, div_res_o.valid, div_busy_o}, 0);
      rstn_i = 1'b1;
      for (int i = 0; i <= 10; i++) go(op_t'(i), PREC_DBL, 0);
      for (int i = 11; i <= 16; i++) begin
         go(i > 14 ? OP_FDIV : op_t'(i), i == 15 ? PREC_DBL : i == 16 ? PREC_EXT : PREC_SGL, 1);
         go(OP_FADD, PREC_SGL, 0);
      end
      go(OP_DIVU, PREC_SGL, 1);
      go(OP_DIVS, PREC_SGL, 0);
      u_iss.idle();
      #1;
      chk("refused", div_refused_o, 1);
      go(OP_FSQRT, PREC_DBL, 0);
      u_iss.idle();
      #1;
      chk("unimp", {unimp_exc_o, unimp_tag_o}, {1'b1, lt});
      for (int i = 0; i < 30; i++) begin
         k = $unsigned($random(seed)) % 15;
         go(op_t'(k), prec_t'($unsigned($random(seed)) % 3), k >= 11);
      end
      u_iss.idle();
      for (int n = 0; n < 40 && q[0].size() + q[1].size() + q[2].size() > 0; n++)
         @(posedge clk_i);
      if (q[0].size() + q[1].size() + q[2].size() > 0) chk("drain", 1, 0);
      print_verdict();
   end
endmodule
